/* File: logic/dcc_pkg.sv */
// constants shared by the dual comparator control block
package dcc_pkg;
   // =========================================================
   // sizes
   localparam int ADDR_W    = 4;
   localparam int DATA_W    = 16;
   localparam int NUM_UNITS = 2;
   localparam int CH_W      = 2;

   // =========================================================
   // register offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL1    = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_CTRL2    = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_STAT     = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_IRQ_CLR  = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_IRQ_EN   = 4'h5;

   // =========================================================
   // comparator_control fields
   localparam int BIT_ENABLE  = 15;
   localparam int BIT_PIN_OE  = 14;
   localparam int BIT_INVERT  = 13;
   localparam int BIT_LOWPWR  = 12;
   localparam int BIT_EVENT   = 9;
   localparam int BIT_RESULT  = 8;
   localparam int BIT_EDGE_HI = 7;
   localparam int BIT_EDGE_LO = 6;
   localparam int BIT_REFSEL  = 4;
   localparam int BIT_CHAN_HI = 1;
   localparam int BIT_CHAN_LO = 0;
   localparam logic [DATA_W-1:0] CTRL_WR_MASK = 16'hf0d3;
   localparam logic [DATA_W-1:0] CTRL_RD_MASK = 16'hf3d3;
   localparam logic [DATA_W-1:0] CTRL_RESET   = 16'h0000;

   // =========================================================
   // comparator_shared_status fields
   localparam int BIT_IDLE_HALT = 15;
   localparam int BIT_STAT_EVT0 = 8;
   localparam int BIT_STAT_RES0 = 0;

   // =========================================================
   // codes
   localparam logic [1:0] EDGE_ANY  = 2'h3;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_OFF  = 2'h0;
   localparam logic [CH_W-1:0] CH_HALF_BANDGAP = 2'h3;
endpackage

/* File: logic/dcc_top.sv */
// control and status for a pair of analog comparators
//
// Overview of operation
// R1: There are two independent comparators, each with its own input selection and control register.
// R2: Inputs choose among four external pins, and the non-inverting side may take a reference.
// R3: One reference is half the band gap voltage, the other the reference-ladder voltage.
// R4: With pin output enable set, the unsynchronised result drives the result pin; this design drives it only while the unit is enabled.
// R5: Control upper byte: 15 enable, 14 pin output enable, 13 invert, 12 low power, 9 event, 8 result.
// R6: Control lower byte: 7:6 event edge select, 4 reference select, 1:0 channel; others read zero.
// R7: With invert set the output is inverted before status, pin and event logic.
// R8: The chosen event sets the event flag, and no trigger or interrupt follows until it is cleared.
// R9: Edge code 11 any change, 10 and 01 one direction each after polarity, 00 none.
// R10: Reference select 1 ties the non-inverting input to the ladder, 0 to the unit's A pin.
// R11: With idle halt set and the device idle, comparators run but raise no interrupts.
// R12: Shared status shows event flags in bits 9 and 8 and results in bits 1 and 0.
// R13: Shared status event bits follow the flags at once, clears included.
// R14: The output is passed through a two-stage synchroniser before status and events use it.
// R15: A disabled comparator reads result zero and sets no event flag.
// R16: The interrupt request rises in the same cycle as the event flag, unless idle halts it.
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
module dcc_top (
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        SYS_RST,
   // register port
   input  wire logic [3:0]  REG_ADDR,
   input  wire logic [15:0] REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic      [15:0] REG_RDATA,
   // analog side
   input  wire logic [1:0]  CMP_RAW,
   input  wire logic        IDLE_MODE,
   output logic      [1:0]  UNIT_ENABLE,
   output logic      [1:0]  LOW_POWER_SELECT,
   output logic      [1:0]  LADDER_REFERENCE_SELECT,
   output logic      [3:0]  INVERTING_CHANNEL_SELECT,
   output logic      [1:0]  HALF_BANDGAP_SELECT,
   // result pins
   output logic      [1:0]  RESULT_PIN,
   output logic      [1:0]  RESULT_PIN_OE,
   // interrupt
   output logic             IRQ
);
   localparam int NU = dcc_pkg::NUM_UNITS;
   localparam int DW = dcc_pkg::DATA_W;

   typedef struct packed {
      logic [NU-1:0][DW-1:0] ctrl;
      logic                  idle_halt;
      logic [NU-1:0]         irq_status;
      logic [NU-1:0]         irq_enable;
      logic [DW-1:0]         rdata;
   } dcc_top_state_t;

   dcc_top_state_t s_reg;
   dcc_top_state_t s_next;
   logic [NU-1:0]  evt_flag_w;
   logic [NU-1:0]  evt_set_w;
   logic [NU-1:0]  res_w;
   logic [NU-1:0]  irq_clear;
   logic [DW-1:0]  stat_view;
   logic           halt_now;

   // =========================================================
   // decode helpers
   function automatic logic ctrl_hit(input logic [3:0] addr, input int idx);
      ctrl_hit = 1'b0;
      if (idx == 0) begin
         ctrl_hit = addr == dcc_pkg::OFS_CTRL1;
      end else if (idx == 1) begin
         ctrl_hit = addr == dcc_pkg::OFS_CTRL2;
      end
   endfunction

   function automatic logic [15:0] ctrl_view(input logic [15:0] stored,
                                              input logic evt,
                                              input logic res);
      logic [15:0] v;
      v                      = stored & dcc_pkg::CTRL_WR_MASK;
      v[dcc_pkg::BIT_EVENT]  = evt;
      v[dcc_pkg::BIT_RESULT] = res;
      ctrl_view              = v;
   endfunction

   // =========================================================
   // comparator units
   generate
      for (genvar g = 0; g < NU; g++) begin : g_unit
         dcc_unit_if uif ();

         assign uif.enable      = s_reg.ctrl[g][dcc_pkg::BIT_ENABLE];    // R1
         assign uif.invert      = s_reg.ctrl[g][dcc_pkg::BIT_INVERT];    // R7
         assign uif.edge_sel    =
            s_reg.ctrl[g][dcc_pkg::BIT_EDGE_HI:dcc_pkg::BIT_EDGE_LO];    // R9
         // writing zero to the event bit clears it, writing one keeps it
         assign uif.event_clear = REG_WR && ctrl_hit(REG_ADDR, g)
                                  && !REG_WDATA[dcc_pkg::BIT_EVENT];     // R8
         assign evt_flag_w[g]   = uif.event_flag;
         assign evt_set_w[g]    = uif.event_set;
         assign res_w[g]        = uif.result;

         dcc_unit u_unit (
            .clk     (CLK),
            .sys_rst (SYS_RST),
            .raw_in  (CMP_RAW[g]),
            .u       (uif)
         );

         // analog switch controls
         assign UNIT_ENABLE[g]      = s_reg.ctrl[g][dcc_pkg::BIT_ENABLE];
         assign LOW_POWER_SELECT[g] = s_reg.ctrl[g][dcc_pkg::BIT_LOWPWR];
         assign LADDER_REFERENCE_SELECT[g] =
            s_reg.ctrl[g][dcc_pkg::BIT_REFSEL];                          // R10 R3
         assign INVERTING_CHANNEL_SELECT[2*g+1:2*g] =
            s_reg.ctrl[g][dcc_pkg::BIT_CHAN_HI:dcc_pkg::BIT_CHAN_LO];    // R2
         assign HALF_BANDGAP_SELECT[g] =
            s_reg.ctrl[g][dcc_pkg::BIT_CHAN_HI:dcc_pkg::BIT_CHAN_LO]
            == dcc_pkg::CH_HALF_BANDGAP;                                 // R3

         // pin path skips the synchroniser so it follows the analog edge
         assign RESULT_PIN[g]    = (CMP_RAW[g] ^ s_reg.ctrl[g][dcc_pkg::BIT_INVERT])
                                   & s_reg.ctrl[g][dcc_pkg::BIT_ENABLE];  // R4 R7
         assign RESULT_PIN_OE[g] = s_reg.ctrl[g][dcc_pkg::BIT_PIN_OE]
                                   & s_reg.ctrl[g][dcc_pkg::BIT_ENABLE];  // R4
      end
   endgenerate

   // =========================================================
   // shared status view
   always_comb begin
      stat_view = '0;
      stat_view[dcc_pkg::BIT_IDLE_HALT] = s_reg.idle_halt;              // R11
      for (int i = 0; i < NU; i++) begin
         stat_view[dcc_pkg::BIT_STAT_EVT0 + i] = evt_flag_w[i];         // R12 R13
         stat_view[dcc_pkg::BIT_STAT_RES0 + i] = res_w[i];              // R12
      end
   end

   // =========================================================
   // register file and interrupt state
   always_comb begin
      s_next       = s_reg;
      s_next.rdata = '0;
      irq_clear    = '0;
      halt_now     = s_reg.idle_halt && IDLE_MODE;                      // R11

      // writes
      for (int i = 0; i < NU; i++) begin
         if (REG_WR && ctrl_hit(REG_ADDR, i)) begin
            s_next.ctrl[i] = REG_WDATA & dcc_pkg::CTRL_WR_MASK;          // R5 R6
         end
      end
      if (REG_WR) begin
         if (REG_ADDR == dcc_pkg::OFS_STAT) begin
            s_next.idle_halt = REG_WDATA[dcc_pkg::BIT_IDLE_HALT];
         end else if (REG_ADDR == dcc_pkg::OFS_IRQ_CLR) begin
            irq_clear = REG_WDATA[NU-1:0];
         end else if (REG_ADDR == dcc_pkg::OFS_IRQ_EN) begin
            s_next.irq_enable = REG_WDATA[NU-1:0];
         end
      end

      // sticky interrupt bits; a new event wins over a clear
      for (int i = 0; i < NU; i++) begin
         if (evt_set_w[i] && !halt_now) begin
            s_next.irq_status[i] = 1'b1;                                 // R16 R11
         end else if (irq_clear[i]) begin
            s_next.irq_status[i] = 1'b0;
         end
      end

      // reads; data valid in the following cycle only
      if (REG_RD) begin
         if (ctrl_hit(REG_ADDR, 0)) begin
            s_next.rdata = ctrl_view(s_reg.ctrl[0], evt_flag_w[0], res_w[0]); // R5
         end else if (ctrl_hit(REG_ADDR, 1)) begin
            s_next.rdata = ctrl_view(s_reg.ctrl[1], evt_flag_w[1], res_w[1]);
         end else if (REG_ADDR == dcc_pkg::OFS_STAT) begin
            s_next.rdata = stat_view;                                    // R12
         end else if (REG_ADDR == dcc_pkg::OFS_IRQ_STAT) begin
            s_next.rdata = DW'(s_reg.irq_status);
         end else if (REG_ADDR == dcc_pkg::OFS_IRQ_EN) begin
            s_next.rdata = DW'(s_reg.irq_enable);
         end else begin
            s_next.rdata = '0;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         s_reg.ctrl       <= {NU{dcc_pkg::CTRL_RESET}};
         s_reg.idle_halt  <= 1'b0;
         s_reg.irq_status <= '0;
         s_reg.irq_enable <= '0;
         s_reg.rdata      <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign REG_RDATA = s_reg.rdata;
   assign IRQ       = |(s_reg.irq_status & s_reg.irq_enable);

   // =========================================================
   // checks
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SYS_RST);

   sequence clr1_s;
      REG_WR && REG_ADDR == dcc_pkg::OFS_CTRL1
         && !REG_WDATA[dcc_pkg::BIT_EVENT] && !evt_set_w[0];
   endsequence

   sequence rd_stat_s;
      REG_RD && REG_ADDR == dcc_pkg::OFS_STAT;
   endsequence

   pin_enable_a: assert property ( // R4
      $past(REG_WR && REG_ADDR == dcc_pkg::OFS_CTRL1)
      |-> RESULT_PIN_OE[0] == ($past(REG_WDATA[dcc_pkg::BIT_PIN_OE])
                               && $past(REG_WDATA[dcc_pkg::BIT_ENABLE])))
      else $error("pin enable does not follow control write");

   status_mirror_a: assert property ( // R12
      $past(REG_RD && REG_ADDR == dcc_pkg::OFS_STAT)
      |-> REG_RDATA[9:8] == $past(evt_flag_w) && REG_RDATA[1:0] == $past(res_w))
      else $error("status read does not mirror units");

   clear_seen_a: assert property ( // R13
      clr1_s ##1 !evt_set_w[0] ##1 rd_stat_s |=> !REG_RDATA[dcc_pkg::BIT_STAT_EVT0])
      else $error("cleared flag still in status");

   ctrl_unused_a: assert property ( // R6
      $past(REG_RD && REG_ADDR == dcc_pkg::OFS_CTRL2)
      |-> (REG_RDATA & ~dcc_pkg::CTRL_RD_MASK) == '0)
      else $error("unused control bits read nonzero");

   idle_quiet_a: assert property ( // R11
      halt_now |=> (s_reg.irq_status & ~$past(s_reg.irq_status)) == '0)
      else $error("interrupt raised while idle halt active");

   irq_same_a: assert property ( // R16
      evt_set_w[0] && !halt_now
      |=> s_reg.irq_status[0] && evt_flag_w[0])
      else $error("interrupt and flag not set together");
endmodule

/* File: logic/dcc_unit.sv */
// one comparator unit: synchroniser, polarity, edge events, event flag
`timescale 1ns/10ps
module dcc_unit (
   // clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   // raw analog comparator decision, asynchronous
   input  wire logic raw_in,
   // control and status
   dcc_unit_if.unit  u
);
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic prev;
      logic result;
      logic event_flag;
   } dcc_unit_state_t;

   dcc_unit_state_t s_reg;
   dcc_unit_state_t s_next;
   logic            adj;
   logic            fire;

   // =========================================================
   // edge decode on the polarity-adjusted output
   function automatic logic edge_hit(input logic [1:0] sel, input logic was,
                                     input logic now);
      edge_hit = 1'b0;
      if (sel == dcc_pkg::EDGE_ANY) begin
         edge_hit = was != now;
      end else if (sel == dcc_pkg::EDGE_FALL) begin
         edge_hit = was && !now;
      end else if (sel == dcc_pkg::EDGE_RISE) begin
         edge_hit = !was && now;
      end
   endfunction

   // =========================================================
   // next state
   always_comb begin
      s_next        = s_reg;
      s_next.sync1  = raw_in;                                  // R14
      s_next.sync2  = s_reg.sync1;                             // R14
      adj           = s_reg.sync2 ^ u.invert;                  // R7
      // disabled units track the level so re-enabling fires nothing stale
      fire          = u.enable && !s_reg.event_flag
                      && edge_hit(u.edge_sel, s_reg.prev, adj); // R9 R15
      s_next.prev   = adj;
      s_next.result = u.enable & adj;                          // R15
      if (fire) begin
         s_next.event_flag = 1'b1;                             // R8
      end else if (u.event_clear) begin
         s_next.event_flag = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign u.result     = s_reg.result;
   assign u.event_flag = s_reg.event_flag;
   assign u.event_set  = fire;

   // =========================================================
   // checks
   sequence trig_s;
      u.enable && !s_reg.event_flag && (s_reg.prev != adj)
         && (u.edge_sel == dcc_pkg::EDGE_ANY);
   endsequence

   flag_set_a: assert property ( // R8
      @(posedge clk) disable iff (sys_rst) trig_s |=> s_reg.event_flag)
      else $error("event flag not set after output change");

   flag_block_a: assert property ( // R8
      @(posedge clk) disable iff (sys_rst) s_reg.event_flag |-> !u.event_set)
      else $error("trigger taken while event flag set");

   edge_dir_a: assert property ( // R9
      @(posedge clk) disable iff (sys_rst)
      u.event_set |-> (u.edge_sel != dcc_pkg::EDGE_OFF)
         && (u.edge_sel != dcc_pkg::EDGE_FALL || (s_reg.prev && !adj))
         && (u.edge_sel != dcc_pkg::EDGE_RISE || (!s_reg.prev && adj)))
      else $error("event on wrong edge");

   disabled_quiet_a: assert property ( // R15
      @(posedge clk) disable iff (sys_rst)
      !u.enable |-> !u.event_set ##1 !s_reg.result)
      else $error("disabled unit shows activity");

   sync_delay_a: assert property ( // R14
      @(posedge clk) disable iff (sys_rst)
      !$past(sys_rst, 1) && !$past(sys_rst, 2) && !$past(sys_rst, 3)
         && $past(u.enable) && (u.invert == $past(u.invert))
      |-> s_reg.result == ($past(raw_in, 3) ^ u.invert))
      else $error("result bit not three cycles behind raw input");
endmodule

/* File: logic/dcc_unit_if.sv */
// signal bundle between the control registers and one comparator unit
`timescale 1ns/10ps
interface dcc_unit_if;
   logic       enable;
   logic       invert;
   logic [1:0] edge_sel;
   logic       event_clear;
   logic       result;
   logic       event_flag;
   logic       event_set;

   modport ctrl (output enable, invert, edge_sel, event_clear,
                 input  result, event_flag, event_set);
   modport unit (input  enable, invert, edge_sel, event_clear,
                 output result, event_flag, event_set);
endinterface

/* File: tb/dcc_analog_model.sv */
// behavioural analog side: input pins, references and comparator decisions
`timescale 1ns/10ps
module dcc_analog_model #(
   parameter logic [7:0] HALF_BG_LEVEL = 8'h60
) (
   // analog selections made by the block
   input  wire logic [1:0] unit_enable,
   input  wire logic [1:0] ladder_sel,
   input  wire logic [3:0] chan_sel,
   input  wire logic [1:0] half_bg_sel,
   // raw decisions, asynchronous to the clock
   output logic      [1:0] cmp_raw
);
   // ==========================================================
   // levels
   logic [7:0] pin_lvl [2][4];   // per unit: A, B, C, D
   logic [7:0] ladder_lvl;
   logic [1:0] decide;

   task automatic set_pin(input int unit, input int pin, input logic [7:0] v);
      pin_lvl[unit][pin] = v;
   endtask

   task automatic set_ladder(input logic [7:0] v);
      ladder_lvl = v;
   endtask

   initial begin
      ladder_lvl = 8'h00;
      for (int u = 0; u < 2; u++) begin
         for (int p = 0; p < 4; p++) begin
            pin_lvl[u][p] = 8'h00;
         end
      end
   end

   // ==========================================================
   // comparators
   function automatic logic decide_unit(input int u);
      logic [7:0] vp;
      logic [7:0] vn;
      vp = ladder_sel[u] ? ladder_lvl : pin_lvl[u][0];
      vn = half_bg_sel[u] ? HALF_BG_LEVEL : pin_lvl[u][int'(chan_sel[2*u +: 2]) + 1];
      return unit_enable[u] && (vp > vn);
   endfunction

   always_comb begin
      decide[0] = decide_unit(0);
      decide[1] = decide_unit(1);
   end

   // off-edge change so the block sees a truly asynchronous input
   assign #1 cmp_raw = decide;
endmodule

/* File: tb/dcc_top_tb_top.sv */
// self-checking bench for the dual comparator control block
`timescale 1ns/10ps
module dcc_top_tb_top;
   // ==========================================================
   // signals
   logic        clk;
   logic        sys_rst;
   logic [3:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_rdata;
   logic [1:0]  cmp_raw;
   logic        idle_mode;
   logic [1:0]  unit_enable;
   logic [1:0]  low_power_select;
   logic [1:0]  ladder_reference_select;
   logic [3:0]  inverting_channel_select;
   logic [1:0]  half_bandgap_select;
   logic [1:0]  result_pin;
   logic [1:0]  result_pin_oe;
   logic        irq;
   int          fails;
   int          checks;
   logic [15:0] d;
   logic [15:0] cfg;
   logic        ev;

   dcc_top dcc_top_inst (.CLK(clk), .SYS_RST(sys_rst), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
      .CMP_RAW(cmp_raw), .IDLE_MODE(idle_mode), .UNIT_ENABLE(unit_enable),
      .LOW_POWER_SELECT(low_power_select), .LADDER_REFERENCE_SELECT(ladder_reference_select),
      .INVERTING_CHANNEL_SELECT(inverting_channel_select),
      .HALF_BANDGAP_SELECT(half_bandgap_select), .RESULT_PIN(result_pin),
      .RESULT_PIN_OE(result_pin_oe), .IRQ(irq));

   dcc_analog_model dcc_analog_model_inst (.unit_enable(unit_enable),
      .ladder_sel(ladder_reference_select), .chan_sel(inverting_channel_select),
      .half_bg_sel(half_bandgap_select), .cmp_raw(cmp_raw));

   always #2 clk = ~clk;

   // ==========================================================
   // helpers
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 v = reg_rdata;
   endtask

   task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   // true when the chosen edge code fires for an adjusted rising or falling change
   function automatic logic fires(input int c, input logic rising);
      return (c == 3) || (c == 1 && rising) || (c == 2 && !rising);
   endfunction

   task automatic test_done;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ==========================================================
   // watchdog: tests need well under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      test_done();
   end

   // ==========================================================
   // tests
   initial begin
      clk = 1'b0; sys_rst = 1'b1; reg_addr = 4'h0; reg_wdata = 16'h0000;
      reg_wr = 1'b0; reg_rd = 1'b0; idle_mode = 1'b0; fails = 0; checks = 0;
      cyc(3);
      sys_rst <= 1'b0;
      // reset values, write-only and unmapped places read zero
      foreach (d[i]) begin
         if (i < 6 || i == 15) begin
            rd(4'(i), d);
            chk("reset read", d, 16'h0000);
         end
      end
      // fields of a disabled unit: writable bits, event write of 1 ignored
      wr(dcc_pkg::OFS_CTRL1, 16'h7fff);
      rd(dcc_pkg::OFS_CTRL1, d);
      chk("ctrl1 fields", d, 16'h70d3);
      chk("low power pin", 16'(low_power_select[0]), 16'h0001);
      chk("disabled oe", 16'(result_pin_oe[0]), 16'h0000);
      chk("channel pins", 16'(inverting_channel_select[1:0]), 16'h0003);
      chk("half bandgap", 16'(half_bandgap_select[0]), 16'h0001);
      chk("ladder select", 16'(ladder_reference_select[0]), 16'h0001);
      wr(dcc_pkg::OFS_IRQ_EN, 16'hffff);
      rd(dcc_pkg::OFS_IRQ_EN, d);
      chk("irq enable", d, 16'h0003);
      // every edge code with both polarities on unit 1
      for (int c = 0; c < 4; c++) begin
         for (int i = 0; i < 2; i++) begin
            cfg = {2'h3, i[0], 5'h00, c[1:0], 6'h00};
            dcc_analog_model_inst.set_pin(0, 0, 8'h00);
            wr(dcc_pkg::OFS_CTRL1, cfg);
            cyc(4);
            wr(dcc_pkg::OFS_CTRL1, cfg);
            wr(dcc_pkg::OFS_IRQ_CLR, 16'hffff);
            dcc_analog_model_inst.set_pin(0, 0, 8'h80);
            #2 chk("raw to pin", 16'(result_pin[0]), 16'(!i));
            cyc(4);
            ev = fires(c, !i);
            rd(dcc_pkg::OFS_CTRL1, d);
            chk("first edge", d, cfg | {6'h00, ev, !i[0], 8'h00});
            rd(dcc_pkg::OFS_STAT, d);
            chk("status mirror", d, {6'h00, 1'b0, ev, 7'h00, !i[0]});
            chk("irq level", 16'(irq), 16'(ev));
            rd(dcc_pkg::OFS_IRQ_STAT, d);
            chk("irq status", d, 16'(ev));
            dcc_analog_model_inst.set_pin(0, 0, 8'h00);
            cyc(4);
            ev = ev | fires(c, i);
            rd(dcc_pkg::OFS_CTRL1, d);
            chk("second edge", d, cfg | {6'h00, ev, i[0], 8'h00});
            wr(dcc_pkg::OFS_CTRL1, cfg);
            rd(dcc_pkg::OFS_STAT, d);
            chk("flag cleared", d & 16'h0300, 16'h0000);
            wr(dcc_pkg::OFS_IRQ_CLR, 16'hffff);
            cyc(1);
            chk("irq cleared", 16'(irq), 16'h0000);
         end
      end
      chk("pin oe", 16'(result_pin_oe), 16'h0001);
      // idle halt: flag still sets, no interrupt
      wr(dcc_pkg::OFS_STAT, 16'h8000);
      idle_mode <= 1'b1;
      dcc_analog_model_inst.set_pin(0, 0, 8'h80);
      cyc(4);
      rd(dcc_pkg::OFS_CTRL1, d);
      chk("idle flag", d & 16'h0200, 16'h0200);
      chk("idle irq", 16'(irq), 16'h0000);
      rd(dcc_pkg::OFS_STAT, d);
      chk("idle halt bit", d & 16'h8000, 16'h8000);
      rd(dcc_pkg::OFS_IRQ_STAT, d);
      chk("idle irq status", d, 16'h0000);
      cyc(1);
      idle_mode <= 1'b0;
      // unit 2 on ladder against half band gap
      wr(dcc_pkg::OFS_CTRL2, 16'h8013);
      dcc_analog_model_inst.set_ladder(8'hc0);
      cyc(4);
      rd(dcc_pkg::OFS_CTRL2, d);
      chk("unit2 high", d, 16'h8113);
      chk("unit enable", 16'(unit_enable), 16'h0003);
      chk("unit2 selects", 16'({inverting_channel_select[3:2], half_bandgap_select[1],
          ladder_reference_select[1]}), 16'h000f);
      rd(dcc_pkg::OFS_STAT, d);
      chk("unit2 result", d & 16'h0002, 16'h0002);
      cyc(1);
      #1 chk("rdata one cycle", reg_rdata, 16'h0000);
      dcc_analog_model_inst.set_ladder(8'h10);
      cyc(4);
      rd(dcc_pkg::OFS_CTRL2, d);
      chk("unit2 low", d, 16'h8013);
      // disabled unit: invert flips the adjusted level, no result and no event
      wr(dcc_pkg::OFS_CTRL2, 16'h20c0);
      dcc_analog_model_inst.set_ladder(8'hc0);
      cyc(4);
      rd(dcc_pkg::OFS_CTRL2, d);
      chk("unit2 off", d, 16'h20c0);
      chk("unit2 pin off", 16'(result_pin[1]), 16'h0000);
      chk("unit2 disabled", 16'(unit_enable), 16'h0001);
      test_done();
   end
endmodule
